// ### pfc_pkg.sv
// package of constants and types for the pll frequency configuration block
package pfc_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] PFC_ADDR_OUTDIV = 8'h10;
    localparam logic [7:0] PFC_ADDR_FBINT = 8'h11;
    localparam logic [7:0] PFC_ADDR_FRAC_H = 8'h12;
    localparam logic [7:0] PFC_ADDR_FRAC_M = 8'h13;
    localparam logic [7:0] PFC_ADDR_FRAC_L = 8'h14;
    localparam logic [7:0] PFC_ADDR_CTRL0 = 8'h15;
    localparam logic [7:0] PFC_ADDR_CTRL1 = 8'h50;
    localparam logic [7:0] PFC_ADDR_SENS = 8'h5A;
    localparam logic [7:0] PFC_ADDR_STATUS = 8'h60;
    localparam logic [7:0] PFC_ADDR_PLLDIV = 8'h64;
    localparam logic [7:0] PFC_ADDR_PLLFB = 8'h68;
    localparam logic [7:0] PFC_ADDR_CENTRE = 8'h6C;

    // ----------------------------------------
    // control register bit positions
    // ----------------------------------------
    localparam int PFC_BIT_OE_REG = 7;
    localparam int PFC_BIT_VCTUNE_DIS = 3;
    localparam int PFC_BIT_CALIB = 2;
    localparam int PFC_BIT_GLITCHLESS = 1;
    localparam int PFC_BIT_RESTORE = 0;

    // ----------------------------------------
    // field widths and factory defaults
    // ----------------------------------------
    localparam int PFC_DIV_W = 4;
    localparam int PFC_INT_W = 6;
    localparam int PFC_FRAC_W = 24;
    localparam int PFC_SENS_W = 4;
    localparam int PFC_RATIO_W = 6;
    localparam logic [3:0] PFC_DEF_SENS = 4'h0;
    localparam logic [3:0] PFC_DEF_DIV = 4'hA;
    localparam logic [5:0] PFC_DEF_INT = 6'h19;
    localparam logic [23:0] PFC_DEF_FRAC = 24'h3B2F2C;

    // ----------------------------------------
    // timing at 40 MHz
    // ----------------------------------------
    localparam int PFC_CLK_PS = 25000;
    localparam int PFC_OE_OFF_NS = 100;
    localparam int PFC_OE_ON_US = 10;
    localparam int PFC_CAL_US = 1500;
    localparam int PFC_OE_OFF_CYC = (PFC_OE_OFF_NS * 1000) / PFC_CLK_PS;
    localparam int PFC_OE_ON_CYC = (PFC_OE_ON_US * 1000000) / PFC_CLK_PS;
    localparam int PFC_CAL_CYC = (PFC_CAL_US * 1000000) / PFC_CLK_PS;
    // two sync flops, off exit and run entry come out of the wake budget
    localparam int PFC_OE_WAKE_LAT = 4;

    typedef enum logic [2:0] {
        PFC_ST_BOOT = 3'b000,
        PFC_ST_RUN = 3'b001,
        PFC_ST_CAL = 3'b010,
        PFC_ST_OFF = 3'b011,
        PFC_ST_WAKE = 3'b100
    } pfc_state_t;

endpackage : pfc_pkg

// ### pfc_div_if.sv
// interface carrying the pll-facing divider code to the ratio decoder and its ratio back
`timescale 1ns/100ps
`default_nettype none
interface pfc_div_if;
    logic [3:0] code;
    logic [5:0] ratio;
    modport src (output code, input ratio);
    modport dec (input code, output ratio);
endinterface : pfc_div_if
`default_nettype wire

// ### pfc_ratio_dec.sv
// output divider code to division ratio decoder
`timescale 1ns/100ps
`default_nettype none
module pfc_ratio_dec
    import pfc_pkg::*;
(
    pfc_div_if.dec div
);
    always_comb begin
        case (div.code)
            4'h0: div.ratio = 6'h04;
            4'h1: div.ratio = 6'h05;
            4'h2: div.ratio = 6'h06;
            4'h3: div.ratio = 6'h07;
            4'h4: div.ratio = 6'h08;
            4'h5: div.ratio = 6'h0A;
            4'h6: div.ratio = 6'h0C;
            4'h7: div.ratio = 6'h0E;
            4'h8: div.ratio = 6'h10;
            4'h9: div.ratio = 6'h14;
            4'hA: div.ratio = 6'h18;
            4'hB: div.ratio = 6'h1C;
            4'hC: div.ratio = 6'h20;
            4'hD: div.ratio = 6'h28;
            4'hE: div.ratio = 6'h30;
            default: div.ratio = 6'h38;
        endcase
    end
endmodule : pfc_ratio_dec
`default_nettype wire

// ### pfc_top.sv
// pll frequency configuration: user and pll register sets, retune, output enable
`timescale 1ns/100ps
`default_nettype none
module pfc_top
    import pfc_pkg::*;
#(
    parameter int CAL_CYC = PFC_CAL_CYC,
    parameter int OE_ON_CYC = PFC_OE_ON_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic oe_pin_i,
    output logic clk_run_o,
    output logic out_standby_o,
    output logic [PFC_SENS_W-1:0] pull_sensitivity_code_o,
    output logic [PFC_DIV_W-1:0] output_divider_code_o,
    output logic [PFC_RATIO_W-1:0] output_ratio_o,
    output logic [PFC_INT_W-1:0] feedback_integer_o,
    output logic [PFC_FRAC_W-1:0] feedback_fraction_o,
    output logic calibrating_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    pfc_state_t st_r, st_nxt;
    logic [3:0] sens_r, sens_nxt;
    logic [3:0] udiv_r, udiv_nxt;
    logic [5:0] uint_r, uint_nxt;
    logic [23:0] ufrac_r, ufrac_nxt;
    logic [3:0] pdiv_r, pdiv_nxt;
    logic [5:0] pint_r, pint_nxt;
    logic [23:0] pfrac_r, pfrac_nxt;
    logic [3:0] cdiv_r, cdiv_nxt;
    logic [5:0] cint_r, cint_nxt;
    logic [23:0] cfrac_r, cfrac_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic oe_s1_r, oe_s2_r;
    logic ld_r, ld_nxt;

    pfc_div_if div_if ();
    pfc_ratio_dec u_dec (.div(div_if));
    assign div_if.code = pdiv_r;

    wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
    wire rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
    wire [7:0] wd = wb_dat_i[7:0];
    wire ctrl_wr = wr && (wb_adr_i == PFC_ADDR_CTRL0 || wb_adr_i == PFC_ADDR_CTRL1);
    // oe_reg bit, when set, masks the pin like an internal disable
    wire oe_on = oe_s2_r && !ctrl_r[PFC_BIT_OE_REG];

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_s1_r <= 1'b0;
            oe_s2_r <= 1'b0;
        end else begin
            oe_s1_r <= oe_pin_i;
            oe_s2_r <= oe_s1_r;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        sens_nxt = sens_r;
        udiv_nxt = udiv_r;
        uint_nxt = uint_r;
        ufrac_nxt = ufrac_r;
        pdiv_nxt = pdiv_r;
        pint_nxt = pint_r;
        pfrac_nxt = pfrac_r;
        cdiv_nxt = cdiv_r;
        cint_nxt = cint_r;
        cfrac_nxt = cfrac_r;
        ctrl_nxt = ctrl_r;
        cnt_nxt = cnt_r;
        ld_nxt = 1'b0;
        // user register writes; allowed any time
        if (wr) begin
            case (wb_adr_i)
                PFC_ADDR_OUTDIV: udiv_nxt = wd[3:0];
                PFC_ADDR_FBINT: uint_nxt = wd[5:0];
                PFC_ADDR_FRAC_H: ufrac_nxt[23:16] = wd;
                PFC_ADDR_FRAC_M: ufrac_nxt[15:8] = wd;
                PFC_ADDR_FRAC_L: ufrac_nxt[7:0] = wd;
                PFC_ADDR_SENS: sens_nxt = wd[3:0];
                PFC_ADDR_CTRL0, PFC_ADDR_CTRL1: begin
                    ctrl_nxt[PFC_BIT_OE_REG] = wd[PFC_BIT_OE_REG];
                    ctrl_nxt[PFC_BIT_VCTUNE_DIS] = wd[PFC_BIT_VCTUNE_DIS];
                end
                default: ;
            endcase
        end
        case (st_r)
            PFC_ST_BOOT: begin
                // defaults already in the user set; push them to the pll set
                pdiv_nxt = udiv_r;
                pint_nxt = uint_r;
                pfrac_nxt = ufrac_r;
                cdiv_nxt = udiv_r;
                cint_nxt = uint_r;
                cfrac_nxt = ufrac_r;
                cnt_nxt = 32'(CAL_CYC);
                st_nxt = PFC_ST_CAL;
            end
            PFC_ST_RUN: begin
                if (ctrl_wr && wd[PFC_BIT_CALIB]) begin
                    // full reload, clock stops while calibrating
                    pdiv_nxt = udiv_r;
                    pint_nxt = uint_r;
                    pfrac_nxt = ufrac_r;
                    cdiv_nxt = udiv_r;
                    cint_nxt = uint_r;
                    cfrac_nxt = ufrac_r;
                    ctrl_nxt[PFC_BIT_CALIB] = 1'b1;
                    cnt_nxt = 32'(CAL_CYC);
                    st_nxt = PFC_ST_CAL;
                end else if (ctrl_wr && wd[PFC_BIT_GLITCHLESS]) begin
                    // divider code untouched: only int and frac move, clock keeps running
                    pint_nxt = uint_r;
                    pfrac_nxt = ufrac_r;
                    ctrl_nxt[PFC_BIT_GLITCHLESS] = 1'b1;
                    ld_nxt = 1'b1;
                end else if (!oe_on) begin
                    cnt_nxt = 32'(PFC_OE_OFF_CYC);
                    st_nxt = PFC_ST_OFF;
                end
                if (ld_r) begin
                    ctrl_nxt[PFC_BIT_GLITCHLESS] = 1'b0;
                end
            end
            PFC_ST_CAL: begin
                if (cnt_r == 32'h00000000) begin
                    ctrl_nxt[PFC_BIT_CALIB] = 1'b0;
                    st_nxt = PFC_ST_RUN;
                end else begin
                    cnt_nxt = cnt_r - 32'h00000001;
                end
            end
            PFC_ST_OFF: begin
                if (oe_on) begin
                    cnt_nxt = 32'(OE_ON_CYC - PFC_OE_WAKE_LAT);
                    st_nxt = PFC_ST_WAKE;
                end
            end
            PFC_ST_WAKE: begin
                // limitation: wake always waits out the whole enable budget, not the real lock time
                if (!oe_on) begin
                    st_nxt = PFC_ST_OFF;
                end else if (cnt_r == 32'h00000000) begin
                    st_nxt = PFC_ST_RUN;
                end else begin
                    cnt_nxt = cnt_r - 32'h00000001;
                end
            end
            default: st_nxt = PFC_ST_BOOT;
        endcase
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    // ack is registered: one wait state, but no combinational path back to the master
    always_comb begin
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt = dat_r;
        if (rd) begin
            case (wb_adr_i)
                PFC_ADDR_OUTDIV: dat_nxt = {28'h0000000, udiv_r};
                PFC_ADDR_FBINT: dat_nxt = {26'h0000000, uint_r};
                PFC_ADDR_FRAC_H: dat_nxt = {24'h000000, ufrac_r[23:16]};
                PFC_ADDR_FRAC_M: dat_nxt = {24'h000000, ufrac_r[15:8]};
                PFC_ADDR_FRAC_L: dat_nxt = {24'h000000, ufrac_r[7:0]};
                PFC_ADDR_CTRL0, PFC_ADDR_CTRL1: dat_nxt = {24'h000000, ctrl_r};
                PFC_ADDR_SENS: dat_nxt = {28'h0000000, sens_r};
                PFC_ADDR_STATUS: dat_nxt = {29'h00000000, st_r};
                PFC_ADDR_PLLDIV: dat_nxt = {28'h0000000, pdiv_r};
                PFC_ADDR_PLLFB: dat_nxt = {2'h0, pint_r, pfrac_r};
                PFC_ADDR_CENTRE: dat_nxt = {cdiv_r, 2'h0, cint_r[5:0], cfrac_r[23:4]};
                default: dat_nxt = 32'h00000000;
            endcase
        end
    end

    // read data stands until the next read, so a slow master still sees it
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dat_r <= 32'h00000000;
            ack_r <= 1'b0;
        end else begin
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
        end
    end

    // ----------------------------------------
    // registers; reset restores factory values
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= PFC_ST_BOOT;
            sens_r <= PFC_DEF_SENS;
            udiv_r <= PFC_DEF_DIV;
            uint_r <= PFC_DEF_INT;
            ufrac_r <= PFC_DEF_FRAC;
            pdiv_r <= PFC_DEF_DIV;
            pint_r <= PFC_DEF_INT;
            pfrac_r <= PFC_DEF_FRAC;
            cdiv_r <= PFC_DEF_DIV;
            cint_r <= PFC_DEF_INT;
            cfrac_r <= PFC_DEF_FRAC;
            ctrl_r <= 8'h00;
            cnt_r <= 32'h00000000;
            ld_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sens_r <= sens_nxt;
            udiv_r <= udiv_nxt;
            uint_r <= uint_nxt;
            ufrac_r <= ufrac_nxt;
            pdiv_r <= pdiv_nxt;
            pint_r <= pint_nxt;
            pfrac_r <= pfrac_nxt;
            cdiv_r <= cdiv_nxt;
            cint_r <= cint_nxt;
            cfrac_r <= cfrac_nxt;
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            ld_r <= ld_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign clk_run_o = (st_r == PFC_ST_RUN);
    assign out_standby_o = (st_r == PFC_ST_OFF) || (st_r == PFC_ST_WAKE);
    assign calibrating_o = (st_r == PFC_ST_CAL) || (st_r == PFC_ST_BOOT);
    assign pull_sensitivity_code_o = sens_r;
    assign output_divider_code_o = pdiv_r;
    assign output_ratio_o = div_if.ratio;
    assign feedback_integer_o = pint_r;
    assign feedback_fraction_o = pfrac_r;

endmodule : pfc_top
`default_nettype wire

// ### pfc_top_monitor.sv
// concurrent checks on the pll frequency configuration ports
`timescale 1ns/100ps
`default_nettype none
module pfc_top_monitor
    import pfc_pkg::*;
#(
    parameter int CAL_CYC = PFC_CAL_CYC,
    parameter int OE_ON_CYC = PFC_OE_ON_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic oe_pin_i,
    input wire logic clk_run_o,
    input wire logic out_standby_o,
    input wire logic [PFC_SENS_W-1:0] pull_sensitivity_code_o,
    input wire logic [PFC_DIV_W-1:0] output_divider_code_o,
    input wire logic [PFC_RATIO_W-1:0] output_ratio_o,
    input wire logic [PFC_INT_W-1:0] feedback_integer_o,
    input wire logic [PFC_FRAC_W-1:0] feedback_fraction_o,
    input wire logic calibrating_o
);
    localparam logic [5:0] RT [16] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0A, 6'h0C, 6'h0E,
        6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h28, 6'h30, 6'h38};
    logic ctl_wr;
    // only retunes issued from a running, enabled output are judged
    assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && clk_run_o && oe_pin_i
        && !wb_dat_i[7] && (wb_adr_i == PFC_ADDR_CTRL0 || wb_adr_i == PFC_ADDR_CTRL1);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ratio_map: assert property (output_ratio_o == RT[output_divider_code_o])
        else $error("divider ratio does not match code");
    a_run_alone: assert property (clk_run_o |-> !out_standby_o && !calibrating_o)
        else $error("running while calibrating or standby");
    a_cal_start: assert property (ctl_wr && wb_dat_i[2] |=> ##[0:2] calibrating_o)
        else $error("calibrated retune did not calibrate");
    a_glitch_keep: assert property (ctl_wr && !wb_dat_i[2] && wb_dat_i[1] |=> clk_run_o [*4])
        else $error("glitchless retune stopped the clock");
    a_fb_hold: assert property (!$stable({feedback_integer_o, feedback_fraction_o}) |-> wb_ack_o || calibrating_o)
        else $error("pll set changed without a retune");
    a_oe_off: assert property ($fell(oe_pin_i) && clk_run_o |-> ##[1:4] out_standby_o)
        else $error("standby too late after enable drop");
    a_oe_wake: assert property ($rose(oe_pin_i) && out_standby_o |-> ##[1:OE_ON_CYC] clk_run_o)
        else $error("clock did not resume after enable");
endmodule : pfc_top_monitor
bind pfc_top pfc_top_monitor #(.CAL_CYC(CAL_CYC), .OE_ON_CYC(OE_ON_CYC)) i_mon (.*);
`default_nettype wire

// ### pfc_host_model.sv
// wishbone master standing in for the configuring host
`timescale 1ns/100ps
`default_nettype none
module pfc_host_model (
    input wire logic clk_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output var logic wb_cyc_o,
    output var logic wb_stb_o,
    output var logic wb_we_o,
    output var logic [7:0] wb_adr_o,
    output var logic [3:0] wb_sel_o,
    output var logic [31:0] wb_dat_o
);
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
    end
    // callers never pass sensitivity codes above 0xB
    task wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o} <= {2'b11, w, a, 4'hF};
        wb_dat_o <= {24'h000000, d};
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'b000;
        // released data is scrambled so stale values cannot pass
        wb_dat_o <= ~wb_dat_o;
    endtask : wb_xfer
endmodule : pfc_host_model
`default_nettype wire

// ### test_pll_frequency_config.sv
// self-checking testbench of the pll frequency configuration block
`timescale 1ns/100ps
`default_nettype none
module test_pll_frequency_config;
    import pfc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic oe = 1'b1;
    logic cyc, stb, we, ack, run, stby, cal;
    logic [7:0] adr;
    logic [3:0] sel, sens, div;
    logic [31:0] wdat, rdat, rd;
    logic [5:0] rat, fint;
    logic [23:0] frac;
    int err_count = 0;
    int checks_done = 0;
    int seed = 32'h33cd;
    int ud, ui, uf, ed, ei, ef;

    pfc_top #(.CAL_CYC(20), .OE_ON_CYC(10)) i_dut (.clk_sys_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .oe_pin_i(oe), .clk_run_o(run), .out_standby_o(stby), .pull_sensitivity_code_o(sens),
        .output_divider_code_o(div), .output_ratio_o(rat), .feedback_integer_o(fint),
        .feedback_fraction_o(frac), .calibrating_o(cal));
    pfc_host_model i_host (.clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    function automatic int ratio(input int c);
        int t[$] = {4, 5, 6, 7, 8, 10, 12, 14, 16, 20, 24, 28, 32, 40, 48, 56};
        return t[c];
    endfunction : ratio

    task wr(input logic [7:0] a, input logic [7:0] d);
        i_host.wb_xfer(1'b1, a, d, rd);
        #1;
    endtask : wr

    task rdr(input logic [7:0] a);
        i_host.wb_xfer(1'b0, a, 8'h00, rd);
    endtask : rdr

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task wait_run();
        for (int n = 0; n < 200 && run !== 1'b1; n++) @(posedge clk);
        #1;
        check(run, 1);
    endtask : wait_run

    task chk_pll();
        check(div, ed);
        check(rat, ratio(ed));
        check(fint, ei);
        check(frac, ef);
    endtask : chk_pll

    task put_user();
        // integer kept within the usable vco window
        ui = 18 + $unsigned($random(seed)) % 15;
        // low fraction nibble held at its factory value
        uf = ($random(seed) & 'hFFFFF0) | (PFC_DEF_FRAC & 'hF);
        wr(PFC_ADDR_OUTDIV, ud[7:0]);
        wr(PFC_ADDR_FBINT, ui[7:0]);
        wr(PFC_ADDR_FRAC_H, uf[23:16]);
        wr(PFC_ADDR_FRAC_M, uf[15:8]);
        wr(PFC_ADDR_FRAC_L, uf[7:0]);
    endtask : put_user

    initial begin
        #(25 * 20000);
        err_count++;
        $display("watchdog expired at %0t", $time);
        end_sim();
    end

    initial begin
        ed = 'hA;
        ei = 'h19;
        ef = 'h3B2F2C;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        #1 check(cal, 1);
        chk_pll();
        check(sens, 0);
        wait_run();
        $display("test defaults done");
        for (int k = 0; k < 12; k++) begin // ends on 0xB, the least sensitive code
            wr(PFC_ADDR_SENS, k[7:0]);
            check(sens, k);
        end
        rdr(PFC_ADDR_SENS);
        check(rd[3:0], 4'hB);
        rdr(8'h20);
        check(rd, 0);
        $display("test sensitivity done");
        for (int c = 0; c < 16; c++) begin // either of the two control register addresses may be used
            ud = c;
            put_user();
            chk_pll();
            wr(c[0] ? PFC_ADDR_CTRL1 : PFC_ADDR_CTRL0, 8'h04);
            tick(1);
            check(cal, 1);
            check(run, 0);
            wait_run();
            ed = ud;
            ei = ui;
            ef = uf;
            chk_pll();
            rdr(PFC_ADDR_CENTRE);
            check(rd, (ed << 28) | (ei << 20) | (ef >> 4));
            rdr(c[0] ? PFC_ADDR_CTRL1 : PFC_ADDR_CTRL0);
            check(rd[2:1], 2'b00);
        end
        $display("test calibrated retune done");
        ud = ed ^ 1;
        put_user();
        wr(PFC_ADDR_CTRL1, 8'h02);
        check(run, 1);
        ei = ui;
        ef = uf;
        chk_pll();
        rdr(PFC_ADDR_PLLFB);
        check(rd, (ei << 24) | ef);
        tick(3);
        rdr(PFC_ADDR_CTRL1);
        check(rd[2:1], 2'b00);
        rdr(PFC_ADDR_CENTRE);
        check(rd[31:28], ed);
        $display("test glitchless retune done");
        @(posedge clk);
        oe <= 1'b0;
        tick(4);
        check(stby, 1);
        @(posedge clk);
        oe <= 1'b1;
        // resume must fit the ten-cycle enable budget given to the instance
        tick(10);
        wait_run();
        check(stby, 0);
        wr(PFC_ADDR_CTRL0, 8'h80);
        tick(3);
        check(stby, 1);
        wr(PFC_ADDR_CTRL0, 8'h00);
        tick(10);
        check(run, 1);
        $display("test output enable done");
        @(posedge clk);
        rstn <= 1'b0;
        tick(2);
        ed = 'hA;
        ei = 'h19;
        ef = 'h3B2F2C;
        chk_pll();
        check(sens, 0);
        @(posedge clk);
        rstn <= 1'b1;
        wait_run();
        $display("test second reset done");
        end_sim();
    end
endmodule : test_pll_frequency_config
`default_nettype wire
